/* File: bench/flash_array_model.sv */
// Behavioural flash array that answers erase starts from the block
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Command side and bench controls
   input  wire logic       cmd_start,
   input  wire logic [1:0] fail,
   input  wire logic [3:0] hold,
   // Result side
   output logic            flash_busy,
   output logic            flash_done,
   output logic            flash_prog_err,
   output logic            flash_prot_err
);
   logic [3:0] cnt;
   logic       start_q;

   always_ff @(posedge clk) begin
      start_q        <= cmd_start;
      flash_done     <= 1'b0;
      flash_prog_err <= 1'b0;
      flash_prot_err <= 1'b0;
      if (!rstn) begin
         flash_busy <= 1'b0;
         cnt        <= 4'h0;
      end else if (cmd_start && !start_q && !flash_busy) begin
         flash_busy <= 1'b1;
         cnt        <= hold;
      end else if (flash_busy) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h0) begin
            flash_busy     <= 1'b0;
            flash_done     <= (fail == 2'h0);
            flash_prot_err <= fail[0];
            flash_prog_err <= fail[1];
         end
      end
   end
endmodule // flash_array_model
`default_nettype wire

/* File: bench/flash_command_control_test.sv */
// Self-checking bench for the flash command register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("BAD at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module flash_command_control_test;
   import flash_cmd_pkg::*;
   // Arbitrary identifier value for this bench
   localparam logic [31:0] TB_PID = 32'h0000_0042;
   logic clk, rstn, read, write, fault_irq, done_irq, ob_write_en;
   logic [8:0]  address;
   logic [31:0] writedata, readdata, cmd_address;
   logic [3:0]  byteenable, hold;
   logic [1:0]  fail;
   logic [15:0] opt_security, opt_user;
   logic [31:0] opt_data;
   logic [63:0] opt_protect;
   logic waitrequest, cmd_program, cmd_page_erase, cmd_mass_erase;
   logic cmd_ob_program, cmd_ob_erase, cmd_start;
   logic flash_busy, flash_done, flash_prog_err, flash_prot_err;
   logic [6:0]  cmd_vec;
   int n_errors, checks_done, cycles;

   assign cmd_vec = {cmd_start, cmd_ob_erase, cmd_ob_program, 1'b0,
                     cmd_mass_erase, cmd_page_erase, cmd_program};

   flash_command_control #(.PART_ID(TB_PID)) flash_command_control_inst (
      .clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .opt_security(opt_security), .opt_user(opt_user),
      .opt_data(opt_data), .opt_protect(opt_protect),
      .cmd_program(cmd_program), .cmd_page_erase(cmd_page_erase),
      .cmd_mass_erase(cmd_mass_erase), .cmd_ob_program(cmd_ob_program),
      .cmd_ob_erase(cmd_ob_erase), .cmd_start(cmd_start),
      .ob_write_en(ob_write_en), .cmd_address(cmd_address),
      .flash_busy(flash_busy), .flash_done(flash_done),
      .flash_prog_err(flash_prog_err), .flash_prot_err(flash_prot_err),
      .done_irq(done_irq), .fault_irq(fault_irq));

   flash_array_model flash_array_model_inst (
      .clk(clk), .rstn(rstn), .cmd_start(cmd_start), .fail(fail),
      .hold(hold), .flash_busy(flash_busy), .flash_done(flash_done),
      .flash_prog_err(flash_prog_err), .flash_prot_err(flash_prot_err));

   always #5 clk = ~clk;

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [8:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address   <= a;
      read      <= ~wr;
      write     <= wr;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         n_errors++;
         end_of_test();
      end
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [8:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask

   task automatic keys(input logic [8:0] a);
      wr(a, KEY_FIRST);
      wr(a, KEY_SECOND);
   endtask

   // Arms a command, starts it and waits for the start bit to drop
   task automatic run(input logic [31:0] base);
      int n;
      n = 0;
      wr(OFF_CONTROL, base);
      wr(OFF_CONTROL, base | (32'h1 << CTL_START));
      if (hold > 4'h4) begin
         // Busy bit trails the array by one cycle
         @(posedge clk);
         rd(OFF_STATUS, 32'h1 << STAT_BUSY);
      end
      @(negedge clk);
      while (cmd_start !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (cmd_start !== 1'b0) begin
         n_errors++;
         end_of_test();
      end
      rd(OFF_CONTROL, base);
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 0; rstn = 0; address = 9'h000; read = 0; write = 0;
      writedata = 32'h0; byteenable = 4'hF; fail = 2'h0; hold = 4'h8;
      opt_security = 16'h5AA5; opt_user = 16'h0000;
      opt_data = 32'hED12_CB34; opt_protect = 64'hBB44_CC33_DD22_EE11;
      n_errors = 0; checks_done = 0; cycles = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFF_CONTROL, CTRL_RESET);
      rd(OFF_STATUS, 32'h0);
      rd(OFF_OPT_STATUS, {6'h0, 16'h1234, 8'hFF, 2'b01});
      rd(OFF_PROTECT, 32'h4433_2211);
      wr(OFF_PART_ID, 32'hFFFF_FFFF);
      rd(OFF_PART_ID, TB_PID);
      rd(9'h018, 32'h0);
      $display("test reset values done");
      wr(OFF_CONTROL, 32'h0000_1477);
      rd(OFF_CONTROL, CTRL_RESET);
      keys(OFF_OPT_KEY);
      rd(OFF_CONTROL, CTRL_RESET);
      wr(OFF_CTRL_KEY, KEY_FIRST);
      wr(OFF_CTRL_KEY, 32'h0);
      wr(OFF_CTRL_KEY, KEY_SECOND);
      rd(OFF_CONTROL, CTRL_RESET);
      keys(OFF_CTRL_KEY);
      rd(OFF_CONTROL, 32'h0);
      keys(OFF_OPT_KEY);
      rd(OFF_CONTROL, 32'h1 << CTL_OB_UNLOCK);
      `CHK(ob_write_en, 1'b1)
      wr(OFF_CONTROL, 32'h0);
      rd(OFF_CONTROL, 32'h0);
      $display("test key sequences done");
      for (int b = 0; b < 6; b++) begin
         if (b == 3) continue;
         wr(OFF_CONTROL, 32'h1 << b);
         @(negedge clk);
         `CHK(cmd_vec, 7'h01 << b)
         rd(OFF_CONTROL, 32'h1 << b);
         wr(OFF_CONTROL, 32'h0);
      end
      wr(OFF_ADDRESS, 32'hA5C3_0F96);
      @(negedge clk);
      `CHK(cmd_address, 32'hA5C3_0F96)
      $display("test command bits done");
      run((32'h1 << CTL_PAGE_ER) | (32'h1 << CTL_DONE_IE));
      rd(OFF_STATUS, 32'h1 << STAT_DONE);
      `CHK(done_irq, 1'b1)
      wr(OFF_STATUS, 32'h1 << STAT_DONE);
      rd(OFF_STATUS, 32'h0);
      `CHK(done_irq, 1'b0)
      hold <= 4'h0;
      run(32'h1 << CTL_MASS_ER);
      rd(OFF_STATUS, 32'h1 << STAT_DONE);
      `CHK(done_irq, 1'b0)
      wr(OFF_STATUS, 32'h1 << STAT_DONE);
      for (int f = 1; f < 3; f++) begin
         fail <= f[1:0];
         run((32'h1 << CTL_FAULT_IE) | (32'h1 << CTL_PAGE_ER));
         rd(OFF_STATUS, (f == 1) ? 32'h10 : 32'h04);
         `CHK(fault_irq, 1'b1)
         wr(OFF_CONTROL, 32'h1 << CTL_PAGE_ER);
         @(negedge clk);
         `CHK(fault_irq, 1'b0)
         wr(OFF_STATUS, 32'h14);
      end
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_CONTROL, CTRL_RESET);
      wr(OFF_CONTROL, 32'h1);
      rd(OFF_CONTROL, CTRL_RESET);
      $display("test operations done");
      rstn <= 1'b0;
      opt_security <= 16'h00FF;
      opt_user <= 16'hA55A;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFF_OPT_STATUS, {6'h0, 16'h1234, 8'h5A, 2'b10});
      rd(OFF_CONTROL, CTRL_RESET);
      $display("test second reset done");
      end_of_test();
   end
endmodule // flash_command_control_test
`default_nettype wire

/* File: logic/flash_cmd_pkg.sv */
// Constants for the flash command and status register block
package flash_cmd_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [8:0] OFF_CTRL_KEY   = 9'h004;
   localparam logic [8:0] OFF_OPT_KEY    = 9'h008;
   localparam logic [8:0] OFF_STATUS     = 9'h00C;
   localparam logic [8:0] OFF_CONTROL    = 9'h010;
   localparam logic [8:0] OFF_ADDRESS    = 9'h014;
   localparam logic [8:0] OFF_OPT_STATUS = 9'h01C;
   localparam logic [8:0] OFF_PROTECT    = 9'h020;
   localparam logic [8:0] OFF_PART_ID    = 9'h100;

   // ---------------------------------------------------------------
   // Control register bit positions
   // ---------------------------------------------------------------
   localparam int CTL_PROGRAM   = 0;
   localparam int CTL_PAGE_ER   = 1;
   localparam int CTL_MASS_ER   = 2;
   localparam int CTL_OB_PROG   = 4;
   localparam int CTL_OB_ERASE  = 5;
   localparam int CTL_START     = 6;
   localparam int CTL_LOCKED    = 7;
   localparam int CTL_OB_UNLOCK = 9;
   localparam int CTL_FAULT_IE  = 10;
   localparam int CTL_DONE_IE   = 12;

   // ---------------------------------------------------------------
   // Status register bit positions
   // ---------------------------------------------------------------
   localparam int STAT_BUSY  = 0;
   localparam int STAT_PGERR = 2;
   localparam int STAT_WPERR = 4;
   localparam int STAT_DONE  = 5;

   // ---------------------------------------------------------------
   // Option status field positions
   // ---------------------------------------------------------------
   localparam int OBS_MISMATCH = 0;
   localparam int OBS_SECURITY = 1;
   localparam int OBS_USER_LSB = 2;
   localparam int OBS_DATA_LSB = 10;

   // ---------------------------------------------------------------
   // Reset values and key words
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0080;
   localparam logic [31:0] KEY_FIRST    = 32'h4567_0123;
   localparam logic [31:0] KEY_SECOND   = 32'hCDEF_89AB;
   localparam logic [7:0]  SEC_OPEN     = 8'hA5;
   localparam logic [7:0]  OPT_BLANK    = 8'hFF;
   // Arbitrary neutral identifier value
   localparam logic [31:0] PART_ID_DEF  = 32'h0000_0001;

endpackage

/* File: logic/flash_command_control.sv */
// Flash command, key, status and option register block on Avalon-MM
//
// Operation
// R1: done interrupt only when control bit 12 enables it.
// R2: fault interrupt only when control bit 10 enables it.
// R3: correct option key pair sets bit 9; software may clear it.
// R4: correct control key pair clears bit 7; software may set it.
// R5: bit 6 starts erase; hardware clears it when busy falls.
// R6: bit 5 selects option byte erase.
// R7: bit 4 selects option byte program.
// R8: bit 2 selects whole array erase.
// R9: bit 1 selects page erase at address register.
// R10: bit 0 selects word program mode.
// R11: software returns command bits to zero after the operation.
// R12: write-only address register at 0x14 gives command address.
// R13: option data value loads into option status 25:10 at reset.
// R14: user option byte loads into option status 9:2 at reset.
// R15: option status bit 1 shows security level.
// R16: mismatched option byte sets bit 0 and reads as 0xFF.
// R17: protection value loads into register 0x20 at reset.
// R18: identifier at 0x100 is a read-only constant.
// R19: software reads option status only by whole words.
// R20: busy stays 1 during an operation, clears at end or error.
// R21: done flag at status bit 5 sets on success, write 1 clears.
// R22: software writes unlock keys as 32-bit words.
// R23: control resets to only the locked bit set.
// R24: while locked, command and enable writes are ignored.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module flash_command_control
   import flash_cmd_pkg::*;
#(
   parameter logic [31:0] PART_ID = PART_ID_DEF
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Avalon-MM slave
   input  wire logic [8:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Option bytes from the option block, sampled after reset
   input  wire logic [15:0] opt_security,
   input  wire logic [15:0] opt_user,
   input  wire logic [31:0] opt_data,
   input  wire logic [63:0] opt_protect,
   // Flash array command side
   output logic             cmd_program,
   output logic             cmd_page_erase,
   output logic             cmd_mass_erase,
   output logic             cmd_ob_program,
   output logic             cmd_ob_erase,
   output logic             cmd_start,
   output logic             ob_write_en,
   output logic      [31:0] cmd_address,
   input  wire logic        flash_busy,
   input  wire logic        flash_done,
   input  wire logic        flash_prog_err,
   input  wire logic        flash_prot_err,
   // Interrupt request lines
   output logic             done_irq,
   output logic             fault_irq
);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic [31:0] control;
   logic [31:0] target_addr;
   logic [5:0]  status;
   logic [31:0] opt_status;
   logic [31:0] protect;
   logic        key_half;
   logic        obkey_half;
   logic        loaded;
   logic        busy_q;
   logic        ack;

   wire         req         = read | write;
   wire         full_word   = byteenable == 4'hF;
   wire         wr_ok       = write & ack & full_word;
   wire         wr_ctrl_key = wr_ok & (address == OFF_CTRL_KEY);
   wire         wr_opt_key  = wr_ok & (address == OFF_OPT_KEY);
   wire         wr_status   = wr_ok & (address == OFF_STATUS);
   wire         wr_control  = wr_ok & (address == OFF_CONTROL);
   wire         wr_address  = wr_ok & (address == OFF_ADDRESS);
   wire         locked      = control[CTL_LOCKED];
   wire         busy_fall   = busy_q & ~flash_busy;

   assign waitrequest = req & ~ack;

   // One wait cycle per access, ack pulses on the second cycle
   always_ff @(posedge clk) begin
      if (!rstn) ack <= 1'b0;
      else       ack <= req & ~ack;
   end

   logic [31:0] rd_mux;
   always_comb begin
      case (address)
         OFF_STATUS:     rd_mux = {26'h0, status};
         OFF_CONTROL:    rd_mux = control;
         OFF_OPT_STATUS: rd_mux = opt_status;
         OFF_PROTECT:    rd_mux = protect;
         OFF_PART_ID:    rd_mux = PART_ID;         // [R18]
         default:        rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn)           readdata <= 32'h0;
      else if (read & ~ack) readdata <= rd_mux;
   end

   // ---------------------------------------------------------------
   // Key sequences
   // ---------------------------------------------------------------
   wire ctl_key_ok = key_half & (writedata == KEY_SECOND);   // [R22]
   wire ob_key_ok  = obkey_half & (writedata == KEY_SECOND);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         key_half   <= 1'b0;
         obkey_half <= 1'b0;
      end else begin
         if (wr_ctrl_key) key_half <= (writedata == KEY_FIRST);
         if (wr_opt_key)  obkey_half <= (writedata == KEY_FIRST);
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   localparam logic [31:0] SW_MASK = 32'h0000_1437;
   logic [31:0] next_control;
   always_comb begin
      next_control = control;
      if (wr_control) begin
         if (!locked) begin                                  // [R24]
            next_control = (control & ~SW_MASK) | (writedata & SW_MASK);
            // [R6] [R7] [R8] [R9] [R10] [R1] [R2]
            if (writedata[CTL_START])
               next_control[CTL_START] = 1'b1;               // [R5]
            if (!writedata[CTL_OB_UNLOCK])
               next_control[CTL_OB_UNLOCK] = 1'b0;           // [R3]
         end
         if (writedata[CTL_LOCKED])
            next_control[CTL_LOCKED] = 1'b1;                 // [R4]
      end
      if (busy_fall)
         next_control[CTL_START] = 1'b0;                     // [R5]
      if (wr_ctrl_key & ctl_key_ok)
         next_control[CTL_LOCKED] = 1'b0;                    // [R4]
      if (wr_opt_key & ob_key_ok & ~locked)
         next_control[CTL_OB_UNLOCK] = 1'b1;                 // [R3]
   end

   always_ff @(posedge clk) begin
      if (!rstn) control <= CTRL_RESET;                      // [R23]
      else       control <= next_control;
   end

   always_ff @(posedge clk) begin
      if (!rstn)           target_addr <= 32'h0;
      else if (wr_address) target_addr <= writedata;         // [R12]
   end

   assign cmd_program    = control[CTL_PROGRAM];             // [R10]
   assign cmd_page_erase = control[CTL_PAGE_ER];             // [R9]
   assign cmd_mass_erase = control[CTL_MASS_ER];             // [R8]
   assign cmd_ob_program = control[CTL_OB_PROG];             // [R7]
   assign cmd_ob_erase   = control[CTL_OB_ERASE];            // [R6]
   assign cmd_start      = control[CTL_START];
   assign ob_write_en    = control[CTL_OB_UNLOCK];
   assign cmd_address    = target_addr;                      // [R12]

   // ---------------------------------------------------------------
   // Status flags, set wins over write-1 clear
   // ---------------------------------------------------------------
   logic [5:0] next_status;
   always_comb begin
      next_status = status;
      if (wr_status)
         next_status = status & ~(writedata[5:0] & 6'h34);   // [R21]
      next_status[STAT_BUSY] = flash_busy;                   // [R20]
      next_status[1] = 1'b0;
      next_status[3] = 1'b0;
      if (flash_done)     next_status[STAT_DONE]  = 1'b1;    // [R21]
      if (flash_prog_err) next_status[STAT_PGERR] = 1'b1;
      if (flash_prot_err) next_status[STAT_WPERR] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status <= 6'h0;
         busy_q <= 1'b0;
      end else begin
         status <= next_status;
         busy_q <= flash_busy;
      end
   end

   assign done_irq  = status[STAT_DONE] & control[CTL_DONE_IE];     // [R1]
   assign fault_irq = (status[STAT_PGERR] | status[STAT_WPERR])
                      & control[CTL_FAULT_IE];                      // [R2]

   // ---------------------------------------------------------------
   // Option byte reload, one cycle after reset release
   // ---------------------------------------------------------------
   function automatic logic [8:0] chk(input logic [15:0] pair);
      logic bad;
      bad = (pair[15:8] != ~pair[7:0]);
      return {bad, bad ? OPT_BLANK : pair[7:0]};             // [R16]
   endfunction

   wire [8:0] sec_c = chk(opt_security);
   wire [8:0] usr_c = chk(opt_user);
   wire [8:0] dl_c  = chk(opt_data[15:0]);
   wire [8:0] dh_c  = chk(opt_data[31:16]);
   logic [31:0] prot_v;
   logic [3:0]  prot_bad;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_prot
         wire [8:0] c = chk(opt_protect[16*g +: 16]);
         assign prot_v[8*g +: 8] = c[7:0];
         assign prot_bad[g]      = c[8];
      end
   endgenerate

   wire any_bad = sec_c[8] | usr_c[8] | dl_c[8] | dh_c[8] | (|prot_bad);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         loaded     <= 1'b0;
         opt_status <= 32'h0;
         protect    <= 32'h0;
      end else if (!loaded) begin
         loaded     <= 1'b1;
         opt_status <= {6'h0, dh_c[7:0], dl_c[7:0],          // [R13]
                        usr_c[7:0],                          // [R14]
                        sec_c[7:0] != SEC_OPEN,              // [R15]
                        any_bad};                            // [R16]
         protect    <= prot_v;                               // [R17]
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_done_irq;
      @(posedge clk) disable iff (!rstn)
      done_irq |-> control[CTL_DONE_IE] && status[STAT_DONE];
   endproperty
   a_done_irq: assert property (p_done_irq) // [R1]
      else $error("done irq without enable");

   property p_fault_irq;
      @(posedge clk) disable iff (!rstn)
      !control[CTL_FAULT_IE] |-> !fault_irq;
   endproperty
   a_fault_irq: assert property (p_fault_irq) // [R2]
      else $error("fault irq while disabled");

   property p_start_clr;
      @(posedge clk) disable iff (!rstn)
      $fell(flash_busy) |=> !control[CTL_START];
   endproperty
   a_start_clr: assert property (p_start_clr) // [R5]
      else $error("start not cleared after busy");

   property p_unlock;
      @(posedge clk) disable iff (!rstn)
      wr_ctrl_key && ctl_key_ok |=> !control[CTL_LOCKED];
   endproperty
   a_unlock: assert property (p_unlock) // [R4]
      else $error("key pair did not unlock");

   property p_lock_hold;
      @(posedge clk) disable iff (!rstn)
      locked && !busy_fall |=> control[5:0] == $past(control[5:0]);
   endproperty
   a_lock_hold: assert property (p_lock_hold) // [R24]
      else $error("command bits changed while locked");

   property p_busy;
      @(posedge clk) disable iff (!rstn)
      flash_busy |=> status[STAT_BUSY];
   endproperty
   a_busy: assert property (p_busy) // [R20]
      else $error("busy status not following");

   property p_done_set;
      @(posedge clk) disable iff (!rstn)
      flash_done |=> status[STAT_DONE];
   endproperty
   a_done_set: assert property (p_done_set) // [R21]
      else $error("done flag lost");

   property p_addr;
      @(posedge clk) disable iff (!rstn)
      wr_address |=> cmd_address == $past(writedata);
   endproperty
   a_addr: assert property (p_addr) // [R12]
      else $error("address not stored");

   property p_ob_unlock;
      @(posedge clk) disable iff (!rstn)
      wr_opt_key && ob_key_ok && !locked |=> ob_write_en;
   endproperty
   a_ob_unlock: assert property (p_ob_unlock) // [R3]
      else $error("option unlock missed");

   property p_opt_stable;
      @(posedge clk) disable iff (!rstn)
      loaded |=> $stable(opt_status) && $stable(protect);
   endproperty
   a_opt_stable: assert property (p_opt_stable) // [R13]
      else $error("option status changed after load");

   property p_done_irq_set;
      @(posedge clk) disable iff (!rstn)
      control[CTL_DONE_IE] && !wr_control && flash_done |=> done_irq;
   endproperty
   a_done_irq_set: assert property (p_done_irq_set) // [R1]
      else $error("enabled done irq not raised");

   property p_fault_set;
      @(posedge clk) disable iff (!rstn)
      control[CTL_FAULT_IE] && !wr_control
         && (flash_prog_err || flash_prot_err) |=> fault_irq;
   endproperty
   a_fault_set: assert property (p_fault_set) // [R2]
      else $error("enabled fault irq not raised");

   property p_ob_clear;
      @(posedge clk) disable iff (!rstn)
      wr_control && !locked && !writedata[CTL_OB_UNLOCK] |=> !ob_write_en;
   endproperty
   a_ob_clear: assert property (p_ob_clear) // [R3]
      else $error("option unlock not cleared by write");

   property p_relock;
      @(posedge clk) disable iff (!rstn)
      wr_control && writedata[CTL_LOCKED] |=> control[CTL_LOCKED];
   endproperty
   a_relock: assert property (p_relock) // [R4]
      else $error("software relock ignored");

   property p_cmd_ob;
      @(posedge clk) disable iff (!rstn)
      wr_control && !locked
         |=> {cmd_ob_erase, cmd_ob_program} == $past(writedata[5:4]);
   endproperty
   a_cmd_ob: assert property (p_cmd_ob) // [R6] [R7]
      else $error("option command bits not written");

   property p_cmd_main;
      @(posedge clk) disable iff (!rstn)
      wr_control && !locked |=> {cmd_mass_erase, cmd_page_erase,
                                 cmd_program} == $past(writedata[2:0]);
   endproperty
   a_cmd_main: assert property (p_cmd_main) // [R8] [R9] [R10]
      else $error("main command bits not written");

   property p_reset_ctrl;
      @(posedge clk)
      !rstn |=> control == CTRL_RESET;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) // [R23]
      else $error("control not at reset value");

   property p_opt_load;
      @(posedge clk) disable iff (!rstn)
      $rose(loaded) |-> opt_status[OBS_MISMATCH] == $past(any_bad)
                        && protect == $past(prot_v);
   endproperty
   a_opt_load: assert property (p_opt_load) // [R16] [R17]
      else $error("option reload wrong");

endmodule // flash_command_control
`default_nettype wire
